/* asr_top.sv */
// adc switch readout and relay output power-loss recovery, wishbone slave
//
// Implementation choices: the Wishbone interface to the registers and the register addresses.
`timescale 1ns/1ns
`default_nettype none
module asr_top
  import asr_pkg::*;
#(
  parameter logic [31:0] FW_VERSION = 32'h0001_0000 // value is arbitrary
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        pwr_ok_i,
  input  wire logic [9:0]  cond_true_i,
  input  wire logic        adc_valid_i,
  input  wire logic [1:0]  adc_ch_i,
  input  wire logic [9:0]  adc_data_i,
  output logic      [9:0]  relay_o,
  output logic      [9:0]  out_led_o,
  output logic      [3:0]  adc_led_o,
  output logic      [1:0]  ref_sel_o,
  output logic             irq_o
);

  logic             ack_reg;
  logic [31:0]      dat_reg;
  logic             run_reg;
  logic [1:0]       ref_reg;
  logic [3:0]       mode_reg;
  logic [9:0]       recov_reg;
  logic [9:0]       cond_en_reg;
  logic [9:0]       out_cmd_reg;
  logic [9:0]       relay_reg;
  logic [9:0]       out_led_reg;
  logic [3:0]       adc_led_reg;
  logic [ADC_W-1:0] thr_reg   [NUM_CH];
  logic [ADC_W-1:0] level_reg [NUM_CH];
  logic [3:0]       sw_reg;
  logic [3:0]       sw_next;
  logic [3:0]       sw_chg;
  logic [31:0]      serial_reg;
  logic [3:0]       irq_st_reg;
  logic [3:0]       irq_st_next;
  logic [3:0]       irq_msk_reg;
  logic             irq_reg;
  asr_pwr_t         pwr_reg;

  logic        req;
  logic        wr;
  logic        cfg_ok;
  logic        restore;
  logic        factory;
  logic [31:0] wmask;
  logic [31:0] rd_mux;
  logic [31:0] wval;
  logic [10:0] smp_x;
  logic [10:0] thr_x;
  logic        up_hit;
  logic        dn_hit;

  assign wb_ack_o  = ack_reg;
  assign wb_dat_o  = dat_reg;
  assign relay_o   = relay_reg;
  assign out_led_o = out_led_reg;
  assign adc_led_o = adc_led_reg;
  assign ref_sel_o = ref_reg;
  assign irq_o     = irq_reg;

  ////////////////////////////////////////////////////////////////////////////
  // bus decode

  assign req     = wb_cyc_i & wb_stb_i & ~ack_reg;
  assign wr      = req & wb_we_i;
  assign cfg_ok  = ~run_reg;
  assign restore = (pwr_reg == ASR_PWR_DOWN) & pwr_ok_i;
  assign factory = wr & (wb_adr_i == OFS_CTRL) & cfg_ok
                   & wval[CTRL_DEF_BIT];

  always_comb begin
    for (int i = 0; i < 4; i++) begin
      wmask[8*i +: 8] = {8{wb_sel_i[i]}};
    end
  end

  // unselected lanes keep their current contents
  assign wval = (rd_mux & ~wmask) | (wb_dat_i & wmask);

  always_comb begin
    rd_mux = 32'h0000_0000;
    case (wb_adr_i)
      OFS_CTRL: begin
        rd_mux[CTRL_RUN_BIT]                = run_reg;
        rd_mux[CTRL_REF_LSB +: 2]           = ref_reg;
        rd_mux[CTRL_MODE_LSB +: NUM_CH]     = mode_reg;
      end
      OFS_RECOV:   rd_mux[9:0] = recov_reg;
      OFS_OUT:     rd_mux[9:0] = out_cmd_reg;
      OFS_COND:    rd_mux[9:0] = cond_en_reg;
      OFS_THR01: begin
        rd_mux[ADC_W-1:0]           = thr_reg[0];
        rd_mux[HI_LSB +: ADC_W]     = thr_reg[1];
      end
      OFS_THR23: begin
        rd_mux[ADC_W-1:0]           = thr_reg[2];
        rd_mux[HI_LSB +: ADC_W]     = thr_reg[3];
      end
      OFS_LVL01: begin
        rd_mux[ADC_W-1:0]           = level_reg[0];
        rd_mux[HI_LSB +: ADC_W]     = level_reg[1];
      end
      OFS_LVL23: begin
        rd_mux[ADC_W-1:0]           = level_reg[2];
        rd_mux[HI_LSB +: ADC_W]     = level_reg[3];
      end
      OFS_SWST:    rd_mux[3:0] = sw_reg;
      OFS_SERIAL:  rd_mux      = serial_reg;
      OFS_FWVER:   rd_mux      = FW_VERSION;
      OFS_IRQ_ST:  rd_mux[3:0] = irq_st_reg;
      OFS_IRQ_MSK: rd_mux[3:0] = irq_msk_reg;
      default:     rd_mux      = 32'h0000_0000;
    endcase
  end

  // one wait state: ack follows the request by one edge, then drops
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_reg <= 1'b0;
      dat_reg <= 32'h0000_0000;
    end else begin
      ack_reg <= req;
      if (req) begin
        dat_reg <= rd_mux;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // configuration

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      run_reg  <= RUN_RST;
      ref_reg  <= REF_AVCC;
      mode_reg <= MODE_RST;
    end else if (wr && wb_adr_i == OFS_CTRL) begin
      run_reg <= wval[CTRL_RUN_BIT];
      if (factory) begin
        ref_reg  <= REF_AVCC;
        mode_reg <= MODE_RST;
      end else if (cfg_ok) begin
        ref_reg  <= wval[CTRL_REF_LSB +: 2];
        mode_reg <= wval[CTRL_MODE_LSB +: NUM_CH];
      end
    end
  end

  // rst_i stands for first power-up; a pwr_ok_i drop keeps all of these
  always_ff @(posedge clk_i) begin
    if (rst_i || factory) begin
      recov_reg   <= RECOV_RST;
      cond_en_reg <= COND_RST;
      for (int c = 0; c < NUM_CH; c++) begin
        thr_reg[c] <= THR_RST;
      end
    end else if (wr && cfg_ok) begin
      case (wb_adr_i)
        OFS_RECOV: recov_reg   <= wval[9:0];
        OFS_COND:  cond_en_reg <= wval[9:0];
        OFS_THR01: begin
          thr_reg[0] <= wval[ADC_W-1:0];
          thr_reg[1] <= wval[HI_LSB +: ADC_W];
        end
        OFS_THR23: begin
          thr_reg[2] <= wval[ADC_W-1:0];
          thr_reg[3] <= wval[HI_LSB +: ADC_W];
        end
        default: ;
      endcase
    end
  end

  // serial number is kept through a factory default
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      serial_reg <= SERIAL_RST;
    end else if (wr && cfg_ok && wb_adr_i == OFS_SERIAL) begin
      serial_reg <= wval;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // power tracking and output recovery

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pwr_reg <= ASR_PWR_DOWN;
    end else begin
      case (pwr_reg)
        ASR_PWR_UP:   if (!pwr_ok_i) pwr_reg <= ASR_PWR_DOWN;
        ASR_PWR_DOWN: if (pwr_ok_i) pwr_reg <= ASR_PWR_UP;
        default:      pwr_reg <= ASR_PWR_DOWN;
      endcase
    end
  end

  // commanded state is held while power is down, acting as retained storage
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      out_cmd_reg <= 10'h000;
    end else if (restore) begin
      out_cmd_reg <= recov_reg & ((cond_en_reg & cond_true_i)
                     | (~cond_en_reg & out_cmd_reg));
    end else if (wr && pwr_reg == ASR_PWR_UP && wb_adr_i == OFS_OUT) begin
      out_cmd_reg <= wval[9:0];
    end
  end

  // an output with a condition only closes while the condition holds
  always_ff @(posedge clk_i) begin
    if (rst_i || pwr_reg != ASR_PWR_UP || !pwr_ok_i) begin
      relay_reg   <= 10'h000;
      out_led_reg <= 10'h000;
    end else begin
      relay_reg   <= out_cmd_reg & (~cond_en_reg | cond_true_i);
      out_led_reg <= out_cmd_reg & (~cond_en_reg | cond_true_i);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // analog channels

  // 11 bits so threshold plus hysteresis cannot wrap
  assign smp_x  = {1'b0, adc_data_i};
  assign thr_x  = {1'b0, thr_reg[adc_ch_i]};
  assign up_hit = smp_x > (thr_x + HYST_STEPS);
  assign dn_hit = (smp_x + HYST_STEPS) < thr_x;

  always_comb begin
    sw_next = sw_reg;
    if (adc_valid_i && mode_reg[adc_ch_i]) begin
      if (up_hit) begin
        sw_next[adc_ch_i] = 1'b1;
      end else if (dn_hit) begin
        sw_next[adc_ch_i] = 1'b0;
      end
    end
  end

  assign sw_chg = sw_next ^ sw_reg;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sw_reg      <= 4'h0;
      adc_led_reg <= 4'h0;
      for (int c = 0; c < NUM_CH; c++) begin
        level_reg[c] <= 10'h000;
      end
    end else begin
      sw_reg      <= sw_next;
      adc_led_reg <= sw_next & mode_reg;
      if (adc_valid_i) begin
        level_reg[adc_ch_i] <= adc_data_i;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // interrupts

  // a new change wins over a write-one-to-clear in the same cycle
  always_comb begin
    irq_st_next = irq_st_reg;
    if (wr && wb_adr_i == OFS_IRQ_ST) begin
      irq_st_next = irq_st_reg & ~(wb_dat_i[3:0] & wmask[3:0]);
    end
    irq_st_next = irq_st_next | sw_chg;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_st_reg  <= 4'h0;
      irq_msk_reg <= MASK_RST;
      irq_reg     <= 1'b0;
    end else begin
      irq_st_reg <= irq_st_next;
      irq_reg    <= |(irq_st_next & irq_msk_reg);
      if (wr && wb_adr_i == OFS_IRQ_MSK) begin
        irq_msk_reg <= wval[3:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
  a_ack_answer: assert property (req |=> wb_ack_o)
    else $error("request not answered on next edge");
  a_recov_keep: assert property (restore |=>
      ((out_cmd_reg ^ $past(out_cmd_reg)) & $past(recov_reg)
       & ~$past(cond_en_reg)) == 10'h000)
    else $error("recovered output lost its previous state");
  a_recov_cond: assert property (restore |=>
      ((out_cmd_reg ^ $past(cond_true_i)) & $past(recov_reg)
       & $past(cond_en_reg)) == 10'h000)
    else $error("conditioned output not set from condition");
  a_recov_off: assert property (restore |=>
      (out_cmd_reg & ~$past(recov_reg)) == 10'h000)
    else $error("non-recovered output not off after power return");
  a_switch_on: assert property (
      adc_valid_i && mode_reg[adc_ch_i] && up_hit
      |=> sw_reg[$past(adc_ch_i)] && adc_led_o[$past(adc_ch_i)])
    else $error("switch state or indicator not on above threshold");
  a_hyst_hold: assert property (
      adc_valid_i && !up_hit && !dn_hit |=> sw_reg == $past(sw_reg))
    else $error("switch changed inside hysteresis band");
  a_led_level: assert property (
      (adc_led_o & ~$past(mode_reg)) == 4'h0)
    else $error("channel indicator lit in level mode");

  a_level_store: assert property (adc_valid_i |=>
      level_reg[$past(adc_ch_i)] == $past(adc_data_i))
    else $error("converted value not stored");

  a_run_locks: assert property (
      run_reg && wr && wb_adr_i == OFS_RECOV |=> $stable(recov_reg))
    else $error("configuration changed in run mode");

  a_out_led: assert property (relay_o == out_led_o)
    else $error("output indicator differs from relay");

  a_irq_level: assert property ((irq_st_reg & irq_msk_reg) != 4'h0
      && !(wr && wb_adr_i == OFS_IRQ_ST) |=> irq_o)
    else $error("interrupt not raised for unmasked status");

  c_restore_on: cover property (restore && (recov_reg != 10'h000));
  c_switch_rise: cover property (sw_chg != 4'h0 ##1 irq_o);
  c_thr_read: cover property (req && !wb_we_i && wb_adr_i == OFS_THR01);

endmodule
`default_nettype wire

/* asr_pkg.sv */
// constants and types shared by the adc switch and output recovery block
package asr_pkg;

  localparam int NUM_OUT = 10;
  localparam int NUM_CH  = 4;
  localparam int ADC_W   = 10;

  // switch hysteresis in conversion steps
  localparam logic [10:0] HYST_STEPS = 11'h008;

  // register byte offsets
  localparam logic [7:0] OFS_CTRL    = 8'h00;
  localparam logic [7:0] OFS_RECOV   = 8'h04;
  localparam logic [7:0] OFS_OUT     = 8'h08;
  localparam logic [7:0] OFS_COND    = 8'h0C;
  localparam logic [7:0] OFS_THR01   = 8'h10;
  localparam logic [7:0] OFS_THR23   = 8'h14;
  localparam logic [7:0] OFS_LVL01   = 8'h18;
  localparam logic [7:0] OFS_LVL23   = 8'h1C;
  localparam logic [7:0] OFS_SWST    = 8'h20;
  localparam logic [7:0] OFS_SERIAL  = 8'h24;
  localparam logic [7:0] OFS_FWVER   = 8'h28;
  localparam logic [7:0] OFS_IRQ_ST  = 8'h2C;
  localparam logic [7:0] OFS_IRQ_MSK = 8'h30;

  // control register fields
  localparam int CTRL_RUN_BIT  = 0;
  localparam int CTRL_REF_LSB  = 1;
  localparam int CTRL_DEF_BIT  = 3;
  localparam int CTRL_MODE_LSB = 4;
  // upper channel of a threshold or level word
  localparam int HI_LSB        = 16;

  // reference source codes
  localparam logic [1:0] REF_AVCC = 2'h0;
  localparam logic [1:0] REF_INT  = 2'h1;
  localparam logic [1:0] REF_EXT  = 2'h2;

  // reset values; MODE_RST, RECOV_RST, COND_RST and THR_RST are also factory values
  localparam logic        RUN_RST    = 1'b1;
  localparam logic [3:0]  MODE_RST   = 4'h0;
  localparam logic [9:0]  RECOV_RST  = 10'h000;
  localparam logic [9:0]  COND_RST   = 10'h000;
  localparam logic [9:0]  THR_RST    = 10'h200;
  localparam logic [31:0] SERIAL_RST = 32'h0000_0000;
  localparam logic [3:0]  MASK_RST   = 4'h0;

  typedef enum logic [1:0] {
    ASR_PWR_DOWN = 2'b01,
    ASR_PWR_UP   = 2'b10
  } asr_pwr_t;

endpackage

/* asr_host.sv */
// host model: wishbone classic master that issues register commands
`timescale 1ns/1ns
`default_nettype none
module asr_host (
  input  wire logic        clk_i,
  input  wire logic        ack_i,
  input  wire logic [31:0] dat_i,
  output logic             cyc_o,
  output logic             stb_o,
  output logic             we_o,
  output logic      [7:0]  adr_o,
  output logic      [3:0]  sel_o,
  output logic      [31:0] dat_o
);
  initial begin
    cyc_o = 1'b0;
    stb_o = 1'b0;
    we_o  = 1'b0;
    adr_o = 8'h00;
    sel_o = 4'h0;
    dat_o = 32'h0000_0000;
  end
  ////////////////////////////////////////////////////////////////////////////
  // one classic cycle; request held until ack is sampled high
  task automatic acc(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    @(posedge clk_i);
    cyc_o <= 1'b1;
    stb_o <= 1'b1;
    we_o  <= w;
    adr_o <= a;
    sel_o <= 4'hF;
    dat_o <= d;
    @(posedge clk_i);
    while (ack_i !== 1'b1) @(posedge clk_i);
    q = dat_i;
    cyc_o <= 1'b0;
    stb_o <= 1'b0;
    we_o  <= 1'b0;
    // released data never keeps the last value
    dat_o <= ~d;
  endtask
endmodule
`default_nettype wire

/* asr_top_tb.sv */
// self-checking bench for the adc switch and output recovery block
`timescale 1ns/1ns
`default_nettype none
module asr_top_tb
  import asr_pkg::*;
;
  localparam logic [31:0] FW = 32'h0001_0000;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        cyc, stb, we, ack, pwr_ok, irq, adc_valid;
  logic [7:0]  adr;
  logic [3:0]  sel, adc_led;
  logic [31:0] wdat, rdat;
  logic [9:0]  cond_true, adc_data, relay, out_led;
  logic [1:0]  adc_ch, ref_sel;
  int          failures = 0;
  int          comparisons = 0;
  always #5 clk = ~clk;
  asr_top #(.FW_VERSION(FW)) i_dut (
    .clk_i(clk), .rst_i(rst), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
    .wb_dat_o(rdat), .wb_ack_o(ack), .pwr_ok_i(pwr_ok),
    .cond_true_i(cond_true), .adc_valid_i(adc_valid), .adc_ch_i(adc_ch),
    .adc_data_i(adc_data), .relay_o(relay), .out_led_o(out_led),
    .adc_led_o(adc_led), .ref_sel_o(ref_sel), .irq_o(irq));
  asr_host i_host (
    .clk_i(clk), .ack_i(ack), .dat_i(rdat), .cyc_o(cyc), .stb_o(stb),
    .we_o(we), .adr_o(adr), .sel_o(sel), .dat_o(wdat));
  ////////////////////////////////////////////////////////////////////////////
  task automatic conclude;
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e) begin
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
      failures++;
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    i_host.acc(1'b1, a, d, q);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    i_host.acc(1'b0, a, 32'h0000_0000, q);
    chk(q, e);
  endtask
  task automatic adc(input logic [1:0] c, input logic [9:0] d);
    @(posedge clk);
    adc_valid <= 1'b1;
    adc_ch    <= c;
    adc_data  <= d;
    @(posedge clk);
    adc_valid <= 1'b0;
    adc_data  <= ~d;
    repeat (3) @(posedge clk);
    #1;
  endtask
  task automatic pwr(input logic v);
    @(posedge clk);
    pwr_ok <= v;
    repeat (4) @(posedge clk);
    #1;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    #100000;
    failures++;
    conclude();
  end
  initial begin
    pwr_ok    = 1'b1;
    cond_true = 10'h001;
    adc_valid = 1'b0;
    adc_ch    = 2'h0;
    adc_data  = 10'h000;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    rdc(OFS_CTRL, 32'h0000_0001);
    rdc(OFS_THR01, 32'h0200_0200);
    rdc(OFS_FWVER, FW);
    rdc(8'h3C, 32'h0000_0000);
    wr(OFS_RECOV, 32'h0000_03FF);
    rdc(OFS_RECOV, 32'h0000_0000);
    // setting mode, then each reference source
    for (int r = 0; r < 3; r++) begin
      wr(OFS_CTRL, 32'h0000_0010 | (r << CTRL_REF_LSB));
      chk(32'(ref_sel), r);
    end
    rdc(OFS_CTRL, 32'h0000_0014);
    wr(OFS_RECOV, 32'h0000_0155);
    rdc(OFS_RECOV, 32'h0000_0155);
    wr(OFS_THR01, 32'h03FF_0064);
    wr(OFS_THR23, 32'h0155_02AA);
    rdc(OFS_THR01, 32'h03FF_0064);
    rdc(OFS_THR23, 32'h0155_02AA);
    wr(OFS_SERIAL, 32'hA5C3_0F96);
    rdc(OFS_SERIAL, 32'hA5C3_0F96);
    // condition on outputs 0 and 1; outputs 0 and 4 commanded off
    wr(OFS_COND, 32'h0000_0003);
    rdc(OFS_COND, 32'h0000_0003);
    wr(OFS_OUT, 32'h0000_03EE);
    repeat (3) @(posedge clk);
    #1;
    chk(32'(relay), 32'h0000_03EC);
    chk(32'(out_led), 32'h0000_03EC);
    pwr(1'b0);
    chk(32'(relay), 32'h0000_0000);
    pwr(1'b1);
    chk(32'(relay), 32'h0000_0145);
    chk(32'(out_led), 32'h0000_0145);
    rdc(OFS_OUT, 32'h0000_0145);
    // second loss with the condition false: output 0 was on and comes back off
    @(posedge clk);
    cond_true <= 10'h000;
    pwr(1'b0);
    pwr(1'b1);
    chk(32'(relay), 32'h0000_0144);
    // ch0 switch at threshold 100, ch1 and ch3 level
    adc(2'h1, 10'h3FF);
    chk(32'(adc_led), 32'h0000_0000);
    adc(2'h3, 10'h2AA);
    adc(2'h0, 10'h06C);
    chk(32'(adc_led), 32'h0000_0000);
    adc(2'h0, 10'h06D);
    chk(32'(adc_led), 32'h0000_0001);
    rdc(OFS_SWST, 32'h0000_0001);
    rdc(OFS_IRQ_ST, 32'h0000_0001);
    chk(32'(irq), 32'h0000_0000);
    wr(OFS_IRQ_MSK, 32'h0000_0001);
    rdc(OFS_IRQ_MSK, 32'h0000_0001);
    repeat (2) @(posedge clk);
    #1;
    chk(32'(irq), 32'h0000_0001);
    wr(OFS_IRQ_ST, 32'h0000_0001);
    repeat (2) @(posedge clk);
    #1;
    chk(32'(irq), 32'h0000_0000);
    adc(2'h0, 10'h05C);
    chk(32'(adc_led), 32'h0000_0001);
    adc(2'h0, 10'h05B);
    chk(32'(adc_led), 32'h0000_0000);
    chk(32'(irq), 32'h0000_0001);
    rdc(OFS_LVL01, 32'h03FF_005B);
    rdc(OFS_LVL23, 32'h02AA_0000);
    // factory default keeps serial, then run mode refuses changes
    wr(OFS_CTRL, 32'h0000_0008);
    rdc(OFS_CTRL, 32'h0000_0000);
    rdc(OFS_THR01, 32'h0200_0200);
    rdc(OFS_SERIAL, 32'hA5C3_0F96);
    wr(OFS_CTRL, 32'h0000_0001);
    wr(OFS_THR01, 32'h0000_0000);
    rdc(OFS_THR01, 32'h0200_0200);
    conclude();
  end
endmodule
`default_nettype wire
